//--- hdl/aprl_pkg.sv
// package: register map, mode word layout and constants of the latch
//
// Contract
// [R1] networked axis: source 00 index, 01 ext one, 10 ext two, 11 ext three
// [R2] encoder axis: source 00 index, 01 first input, 10 second input
// [R3] primary channel captures only while mode bit 2 is set
// [R4] secondary channel captures only while mode bit 6 is set
// [R5] encoder axis: mode bit 3 picks primary edge, 0 rising, 1 falling
// [R6] encoder axis: mode bit 7 picks secondary edge, 0 rising, 1 falling
// [R7] mode bits 9,8: 00 no window, 01 inclusive, 11 exclusive
// [R8] encoder axis: mode bit 10 enables trigger input filtering
// [R9] encoder axis: position latched by hardware in the trigger cycle
// [R10] capture sets the channel flag and stores the channel position
// [R11] inclusive: accept only when open < position < close
// [R12] exclusive: accept only when position lies outside open..close
// [R13] after capture, hold flag and position until a new mode write
package aprl_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] WOPEN_OFS = 8'h08;
  localparam logic [7:0] WCLOSE_OFS = 8'h0c;
  localparam logic [7:0] FLAGS_OFS = 8'h10;
  localparam logic [7:0] IST_OFS = 8'h14;
  localparam logic [7:0] IMASK_OFS = 8'h18;
  localparam logic [7:0] POSA_OFS = 8'h1c;
  localparam logic [7:0] POSB_OFS = 8'h20;
  localparam logic [7:0] MPOS_OFS = 8'h24;

  // reset values
  localparam logic [10:0] MODE_RST = 11'h000;
  localparam logic CFG_RST = 1'b0;
  localparam logic [31:0] WIN_RST = 32'h0000_0000;
  localparam logic [1:0] IMASK_RST = 2'h0;

  // field positions
  localparam int CFG_NET_BIT = 0;
  localparam int FLAGS_ARM_LSB = 2;

  // source codes
  localparam logic [1:0] SRC_INDEX = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL_TRIGGER_THREE = 2'h3;

  // window codes
  localparam logic [1:0] WIN_OFF = 2'h0;
  localparam logic [1:0] WIN_INC = 2'h1;
  localparam logic [1:0] WIN_EXC = 2'h3;

  // samples that must agree before a filtered trigger moves
  localparam int FILT_LEN = 3;

  // mode word, bit 0 at the bottom
  typedef struct packed {
    logic filt;          // bit 10
    logic [1:0] win;     // bits 9,8
    logic edge_b;        // bit 7
    logic en_b;          // bit 6
    logic [1:0] src_b;   // bits 5,4
    logic edge_a;        // bit 3
    logic en_a;          // bit 2
    logic [1:0] src_a;   // bits 1,0
  } aprl_mode_t;

endpackage

//--- hdl/aprl_latch.sv
// axis position registration latch with apb register access
`timescale 1ns/1ps
`default_nettype none
module aprl_latch (
  input wire logic pclk,                   // system clock, 20 MHz
  input wire logic presetn,                // async reset, active low
  input wire logic psel,                   // apb select
  input wire logic penable,                // apb access phase
  input wire logic pwrite,                 // apb direction
  input wire logic [7:0] paddr,            // apb byte address
  input wire logic [31:0] pwdata,          // apb write data
  output logic [31:0] prdata,              // apb read data
  output logic pready,                     // apb ready
  output logic pslverr,                    // apb error, unmapped
  input wire logic encoder_index,          // index mark pin
  input wire logic external_trigger_one,   // registration pin one
  input wire logic external_trigger_two,   // registration pin two
  input wire logic external_trigger_three, // registration pin three
  input wire logic [31:0] measured_position, // same-clock axis position
  output logic primary_capture_flag,       // primary captured
  output logic secondary_capture_flag,     // secondary captured
  output logic irq                         // level interrupt
);

  aprl_pkg::aprl_mode_t mode_r;
  logic net_r;
  logic [31:0] wopen_r;
  logic [31:0] wclose_r;
  logic [1:0] ist_r;
  logic [1:0] imask_r;
  logic [1:0] arm_r;
  logic [1:0] flag_r;
  logic [31:0] pos_r [2];
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic [3:0] pin_w;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] cond_r;
  logic [3:0] prev_r;
  logic [3:0] rise_w;
  logic [3:0] fall_w;
  logic [1:0] evt_w;
  logic [1:0] cap_w;
  logic win_ok_w;
  logic acc_w;
  logic wr_w;
  logic mode_wr_w;
  aprl_pkg::aprl_mode_t wmode_w;
  logic [31:0] rdata_nxt;
  logic slverr_nxt;

  assign pin_w = {external_trigger_three, external_trigger_two,
                  external_trigger_one, encoder_index};

  ////////////////////////////////////////////////////////////////////////
  // trigger conditioning: sync, optional filter, edge detect

  for (genvar i = 0; i < 4; i++) begin : g_pin
    logic [aprl_pkg::FILT_LEN-2:0] hist_r;
    logic stable_w;
    assign stable_w = (hist_r == {(aprl_pkg::FILT_LEN-1){sync2_r[i]}});
    // two flops before anything looks at a pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_r[i] <= 1'b0;
        sync2_r[i] <= 1'b0;
      end else begin
        sync1_r[i] <= pin_w[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
    // filter only moves on agreeing samples; costs FILT_LEN-1 cycles
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hist_r <= '0;
        cond_r[i] <= 1'b0;
        prev_r[i] <= 1'b0;
      end else begin
        hist_r <= {hist_r[aprl_pkg::FILT_LEN-3:0], sync2_r[i]};
        if (!net_r && mode_r.filt) begin // see [R8]
          if (stable_w) begin
            cond_r[i] <= sync2_r[i];
          end
        end else begin
          cond_r[i] <= sync2_r[i];
        end
        prev_r[i] <= cond_r[i];
      end
    end
    assign rise_w[i] = cond_r[i] & ~prev_r[i];
    assign fall_w[i] = ~cond_r[i] & prev_r[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // position window, shared by both channels

  // signed compare so positions either side of zero behave
  always_comb begin
    if (mode_r.win == aprl_pkg::WIN_INC) begin // see [R7]
      win_ok_w = ($signed(measured_position) > $signed(wopen_r)) &&
                 ($signed(measured_position) < $signed(wclose_r)); // see [R11]
    end else if (mode_r.win == aprl_pkg::WIN_EXC) begin
      win_ok_w = ($signed(measured_position) < $signed(wopen_r)) ||
                 ($signed(measured_position) > $signed(wclose_r)); // see [R12]
    end else begin
      // 00 and the unlisted 10 both leave windowing off
      win_ok_w = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture channels, 0 primary and 1 secondary

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [1:0] src_w;
    logic en_w;
    logic fall_sel_w;
    logic valid_w;
    assign src_w = (c == 0) ? mode_r.src_a : mode_r.src_b;
    assign en_w = (c == 0) ? mode_r.en_a : mode_r.en_b; // see [R3] [R4]
    // networked axis has no edge choice: rising only
    assign fall_sel_w = !net_r &&
      ((c == 0) ? mode_r.edge_a : mode_r.edge_b); // see [R5] [R6]
    // encoder axis has no third external input: code 11 never fires
    assign valid_w = net_r || (src_w != aprl_pkg::SRC_EXTERNAL_TRIGGER_THREE); // see [R1] [R2]
    assign evt_w[c] = valid_w &&
      (fall_sel_w ? fall_w[src_w] : rise_w[src_w]);
    assign cap_w[c] = evt_w[c] && arm_r[c] && win_ok_w;

    // capture beats a re-arm in the same cycle so no event is lost
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        arm_r[c] <= 1'b0;
        flag_r[c] <= 1'b0;
      end else if (cap_w[c]) begin
        arm_r[c] <= 1'b0; // see [R13]
        flag_r[c] <= 1'b1; // see [R10]
      end else if (mode_wr_w) begin
        arm_r[c] <= (c == 0) ? wmode_w.en_a : wmode_w.en_b; // see [R3] [R4]
        flag_r[c] <= 1'b0;
      end
    end

    // position taken in the event cycle, no software in the path
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pos_r[c] <= 32'h0000_0000;
      end else if (cap_w[c]) begin
        pos_r[c] <= measured_position; // see [R9] [R10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, then pready for one cycle

  assign acc_w = psel && penable && !pready_r;
  assign wr_w = psel && penable && pready_r && pwrite;
  assign mode_wr_w = wr_w && (paddr == aprl_pkg::MODE_OFS); // see [R13]
  // write data seen through the mode layout, no loose bit numbers
  assign wmode_w = pwdata[$bits(aprl_pkg::aprl_mode_t)-1:0];

  // read mux and unmapped detection
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    slverr_nxt = 1'b0;
    if (paddr == aprl_pkg::MODE_OFS) begin
      rdata_nxt[10:0] = mode_r;
    end else if (paddr == aprl_pkg::CFG_OFS) begin
      rdata_nxt[aprl_pkg::CFG_NET_BIT] = net_r;
    end else if (paddr == aprl_pkg::WOPEN_OFS) begin
      rdata_nxt = wopen_r;
    end else if (paddr == aprl_pkg::WCLOSE_OFS) begin
      rdata_nxt = wclose_r;
    end else if (paddr == aprl_pkg::FLAGS_OFS) begin
      rdata_nxt[1:0] = flag_r;
      rdata_nxt[aprl_pkg::FLAGS_ARM_LSB +: 2] = arm_r;
    end else if (paddr == aprl_pkg::IST_OFS) begin
      rdata_nxt[1:0] = ist_r;
    end else if (paddr == aprl_pkg::IMASK_OFS) begin
      rdata_nxt[1:0] = imask_r;
    end else if (paddr == aprl_pkg::POSA_OFS) begin
      rdata_nxt = pos_r[0];
    end else if (paddr == aprl_pkg::POSB_OFS) begin
      rdata_nxt = pos_r[1];
    end else if (paddr == aprl_pkg::MPOS_OFS) begin
      rdata_nxt = measured_position;
    end else begin
      slverr_nxt = 1'b1;
    end
  end

  // handshake and read data, loaded in the wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= acc_w;
      prdata_r <= (acc_w && !pwrite) ? rdata_nxt : 32'h0000_0000;
      pslverr_r <= acc_w && slverr_nxt;
    end
  end

  // writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= aprl_pkg::MODE_RST;
      net_r <= aprl_pkg::CFG_RST;
      wopen_r <= aprl_pkg::WIN_RST;
      wclose_r <= aprl_pkg::WIN_RST;
      imask_r <= aprl_pkg::IMASK_RST;
    end else if (wr_w) begin
      if (paddr == aprl_pkg::MODE_OFS) begin
        mode_r <= wmode_w;
      end else if (paddr == aprl_pkg::CFG_OFS) begin
        net_r <= pwdata[aprl_pkg::CFG_NET_BIT];
      end else if (paddr == aprl_pkg::WOPEN_OFS) begin
        wopen_r <= pwdata;
      end else if (paddr == aprl_pkg::WCLOSE_OFS) begin
        wclose_r <= pwdata;
      end else if (paddr == aprl_pkg::IMASK_OFS) begin
        imask_r <= pwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt: sticky capture bits, write one to clear, set wins

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      if (wr_w && (paddr == aprl_pkg::IST_OFS)) begin
        ist_r <= (ist_r & ~pwdata[1:0]) | cap_w;
      end else begin
        ist_r <= ist_r | cap_w;
      end
      irq_r <= |(ist_r & imask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign primary_capture_flag = flag_r[0];
  assign secondary_capture_flag = flag_r[1];

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_mode_wr_en_a_off;
    mode_wr_w && !cap_w[0] && !wmode_w.en_a;
  endsequence

  sequence s_cap_a;
    cap_w[0] ##1 flag_r[0];
  endsequence

  property p_pri_disarm;
    s_mode_wr_en_a_off |=> !arm_r[0] && !flag_r[0] ##1 !flag_r[0];
  endproperty
  a_pri_disarm: assert property (p_pri_disarm) // see [R3]
    else $error("primary armed with enable bit clear");

  property p_sec_needs_en;
    cap_w[1] |-> mode_r.en_b;
  endproperty
  a_sec_needs_en: assert property (p_sec_needs_en) // see [R4]
    else $error("secondary captured with enable bit clear");

  property p_pri_store;
    s_cap_a |-> pos_r[0] == $past(measured_position);
  endproperty
  a_pri_store: assert property (p_pri_store) // see [R10]
    else $error("primary position not latched at capture");

  property p_hold;
    flag_r[1] && !mode_wr_w |=> flag_r[1] && $stable(pos_r[1]);
  endproperty
  a_hold: assert property (p_hold) // see [R13]
    else $error("secondary capture not held until re-arm");

  property p_incl;
    cap_w[0] && mode_r.win == aprl_pkg::WIN_INC |->
      $signed(measured_position) > $signed(wopen_r) &&
      $signed(measured_position) < $signed(wclose_r);
  endproperty
  a_incl: assert property (p_incl) // see [R11]
    else $error("capture outside inclusive window");

  property p_excl;
    cap_w[1] && mode_r.win == aprl_pkg::WIN_EXC |->
      !($signed(measured_position) >= $signed(wopen_r) &&
        $signed(measured_position) <= $signed(wclose_r));
  endproperty
  a_excl: assert property (p_excl) // see [R12]
    else $error("capture inside exclusive window");

  property p_pri_fall;
    evt_w[0] && !net_r && mode_r.edge_a |->
      $past(cond_r[mode_r.src_a], 1) && !cond_r[mode_r.src_a];
  endproperty
  a_pri_fall: assert property (p_pri_fall) // see [R5]
    else $error("primary falling edge event without a fall");

  property p_net_external_trigger_three;
    cap_w[0] && net_r && mode_r.src_a == aprl_pkg::SRC_EXTERNAL_TRIGGER_THREE |->
      cond_r[3] && !prev_r[3];
  endproperty
  a_net_external_trigger_three: assert property (p_net_external_trigger_three) // see [R1]
    else $error("networked source 11 not taken from ext three");

  property p_enc_no_src3;
    !net_r && mode_r.src_b == aprl_pkg::SRC_EXTERNAL_TRIGGER_THREE |-> !evt_w[1];
  endproperty
  a_enc_no_src3: assert property (p_enc_no_src3) // see [R2]
    else $error("encoder axis fired on unlisted source");

  property p_irq;
    cap_w[0] && imask_r[0] |-> ##2 irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked capture did not raise irq in two cycles");

  property p_sec_store;
    cap_w[1] |=> secondary_capture_flag &&
      pos_r[1] == $past(measured_position);
  endproperty
  a_sec_store: assert property (p_sec_store) // see [R10]
    else $error("secondary capture did not set flag and position");

  property p_sec_fall;
    evt_w[1] && !net_r && mode_r.edge_b |->
      prev_r[mode_r.src_b] && !cond_r[mode_r.src_b];
  endproperty
  a_sec_fall: assert property (p_sec_fall) // see [R6]
    else $error("secondary falling edge event without a fall");

  // a fresh sample change must not get through the filter at once
  property p_filt_one;
    !net_r && mode_r.filt && $changed(sync2_r[1]) |=> $stable(cond_r[1]);
  endproperty
  a_filt_one: assert property (p_filt_one) // see [R8]
    else $error("filtered trigger moved on a single sample");

endmodule // aprl_latch
`default_nettype wire

//--- verification/aprl_trig_model.sv
// trigger pin model: index mark and three registration sensors
`timescale 1ns/1ps
`default_nettype none
module aprl_trig_model (
  output var logic encoder_index,         // index mark
  output var logic external_trigger_one,  // sensor one
  output var logic external_trigger_two,  // sensor two
  output var logic external_trigger_three // sensor three
);
  // sensors idle low and are always driven, so nothing floats
  initial begin
    encoder_index = 1'b0;
    external_trigger_one = 1'b0;
    external_trigger_two = 1'b0;
    external_trigger_three = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // level change, called right after a rising clock edge
  task automatic set(input int pin, input logic lvl);
    case (pin)
      0: encoder_index <= lvl;
      1: external_trigger_one <= lvl;
      2: external_trigger_two <= lvl;
      default: external_trigger_three <= lvl;
    endcase
  endtask
endmodule // aprl_trig_model
`default_nettype wire

//--- verification/aprl_latch_tb.sv
// self-checking bench for the registration latch
`timescale 1ns/1ps
`default_nettype none
module aprl_latch_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, measured_position, q;
  logic t_idx, t_one, t_two, t_three, flag_a, flag_b;
  logic [1:0] imask_v;
  int failures, checks;

  aprl_latch dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .encoder_index(t_idx), .external_trigger_one(t_one),
    .external_trigger_two(t_two), .external_trigger_three(t_three),
    .measured_position(measured_position),
    .primary_capture_flag(flag_a), .secondary_capture_flag(flag_b),
    .irq(irq));

  aprl_trig_model u_trig (.encoder_index(t_idx),
    .external_trigger_one(t_one), .external_trigger_two(t_two),
    .external_trigger_three(t_three));

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one apb transfer; waits for pready, never assumes a latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pin pulse; position moves at the trailing edge to tell edges apart
  task pulse(input int pin, input logic [31:0] p, input int w);
    measured_position <= p;
    u_trig.set(pin, 1'b1);
    repeat (w) @(posedge pclk);
    if (w > 1) measured_position <= p + 32'h10;
    u_trig.set(pin, 1'b0);
    repeat (12) @(posedge pclk);
  endtask

  // arm, fire one pin, check flags, status, irq and captured position
  task cap(input string nm, input logic c, input logic [10:0] m,
           input int pin, input logic [31:0] p, input logic ea,
           input logic eb, input int w);
    logic [31:0] e;
    e = (!c && (ea ? m[3] : m[7])) ? p + 32'h10 : p;
    apb(1'b1, aprl_pkg::CFG_OFS, {31'h0, c});
    apb(1'b1, aprl_pkg::MODE_OFS, {21'h0, m});
    pulse(pin, p, w);
    chk({30'h0, flag_b, flag_a}, {30'h0, eb, ea});
    apb(1'b0, aprl_pkg::IST_OFS, 32'h0);
    chk(q, {30'h0, eb, ea});
    chk({31'h0, irq}, {31'h0, |({eb, ea} & imask_v)});
    if (ea) begin
      apb(1'b0, aprl_pkg::POSA_OFS, 32'h0);
      chk(q, e);
    end
    if (eb) begin
      apb(1'b0, aprl_pkg::POSB_OFS, 32'h0);
      chk(q, e);
    end
    apb(1'b1, aprl_pkg::IST_OFS, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test %s done", nm);
  endtask

  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    measured_position = 32'h0;
    imask_v = 2'h0;
    failures = 0;
    checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of mode .. mask are all zero
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    measured_position <= 32'h1234_5678;
    apb(1'b0, aprl_pkg::MPOS_OFS, 32'h0);
    chk(q, 32'h1234_5678);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    $display("test regs done");
    apb(1'b1, aprl_pkg::IMASK_OFS, 32'h3);
    imask_v = 2'h3;
    cap("idx_rise", 0, 11'h004, 0, 32'h100, 1, 0, 8);
    // held flag and position ignore a later trigger
    pulse(0, 32'h999, 8);
    apb(1'b0, aprl_pkg::POSA_OFS, 32'h0);
    chk(q, 32'h100);
    apb(1'b0, aprl_pkg::IST_OFS, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, flag_a}, 32'h1);
    apb(1'b0, aprl_pkg::FLAGS_OFS, 32'h0);
    chk(q, 32'h1);
    $display("test hold done");
    cap("one_fall", 0, 11'h00d, 1, 32'h200, 1, 0, 8);
    cap("a_off", 0, 11'h001, 1, 32'h5, 0, 0, 8);
    cap("two_fall", 0, 11'h0e0, 2, 32'h300, 0, 1, 8);
    cap("b_rise", 0, 11'h040, 0, 32'h380, 0, 1, 8);
    cap("b_off", 0, 11'h0a0, 2, 32'h5, 0, 0, 8);
    cap("enc_src3", 0, 11'h007, 3, 32'h5, 0, 0, 8);
    // edge bit ignored on a networked axis
    for (int s = 0; s < 4; s++) begin
      cap("net_a", 1, 11'(12 + s), s, 32'(64 + s), 1, 0, 8);
    end
    cap("net_b", 1, 11'h0f0, 3, 32'h77, 0, 1, 8);
    apb(1'b0, aprl_pkg::CFG_OFS, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, aprl_pkg::WOPEN_OFS, 32'd30);
    apb(1'b1, aprl_pkg::WCLOSE_OFS, 32'd90);
    apb(1'b0, aprl_pkg::WOPEN_OFS, 32'h0);
    chk(q, 32'd30);
    apb(1'b0, aprl_pkg::WCLOSE_OFS, 32'h0);
    chk(q, 32'd90);
    cap("inc_low", 0, 11'h104, 0, 32'd20, 0, 0, 8);
    cap("inc_mid", 0, 11'h104, 0, 32'd60, 1, 0, 8);
    cap("inc_edge", 0, 11'h104, 0, 32'd90, 0, 0, 8);
    cap("exc_mid", 0, 11'h304, 0, 32'd60, 0, 0, 8);
    cap("exc_high", 0, 11'h304, 0, 32'd100, 1, 0, 8);
    cap("exc_edge", 0, 11'h304, 0, 32'd30, 0, 0, 8);
    // unlisted window code 10 leaves windowing off
    cap("win_10", 0, 11'h204, 0, 32'd20, 1, 0, 8);
    cap("filt_glitch", 0, 11'h405, 1, 32'h11, 0, 0, 1);
    cap("filt_long", 0, 11'h405, 1, 32'h22, 1, 0, 8);
    cap("raw_glitch", 0, 11'h005, 1, 32'h33, 1, 0, 1);
    cap("net_nofilt", 1, 11'h405, 1, 32'h44, 1, 0, 1);
    // masked source sets status but leaves irq low
    apb(1'b1, aprl_pkg::IMASK_OFS, 32'h1);
    imask_v = 2'h1;
    cap("masked", 0, 11'h050, 1, 32'h55, 0, 1, 8);
    // arm both, capture both, then reset in mid-run
    apb(1'b1, aprl_pkg::MODE_OFS, 32'h44);
    apb(1'b0, aprl_pkg::MODE_OFS, 32'h0);
    chk(q, 32'h44);
    apb(1'b0, aprl_pkg::FLAGS_OFS, 32'h0);
    chk(q, 32'hc);
    pulse(0, 32'h66, 8);
    apb(1'b0, aprl_pkg::FLAGS_OFS, 32'h0);
    chk(q, 32'h3);
    chk({31'h0, irq}, 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({30'h0, flag_b, flag_a}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, aprl_pkg::POSB_OFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, aprl_pkg::MODE_OFS, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    test_done;
  end
endmodule // aprl_latch_tb
`default_nettype wire
